// ===== fok_regs.svh
`ifndef FOK_REGS_SVH
`define FOK_REGS_SVH

// command codes held in command byte zero
`define FOK_CMD_OTP_PGM 8'h43
`define FOK_CMD_ERASE_ALL 8'h44
`define FOK_CMD_KEY_CHECK 8'h45

// positions inside the command object bytes
`define FOK_BYTE_CODE 0
`define FOK_BYTE_INDEX 1
`define FOK_BYTE_DATA0 4
`define FOK_BYTE_KEY0 4
`define FOK_CMD_BYTES 12

// one-time program area
`define FOK_OTP_RECORDS 16
`define FOK_OTP_IDX_MAX 8'h0f
`define FOK_OTP_ERASED 32'hffff_ffff

// backdoor key patterns that are never accepted
`define FOK_KEY_ZEROS 64'h0000_0000_0000_0000
`define FOK_KEY_ONES 64'hffff_ffff_ffff_ffff

// reset values
`define FOK_CMD_BYTE_RESET 8'h00
`define FOK_LOCKED 1'b0
`define FOK_UNLOCKED 1'b1

`endif

// ===== fok_pkg.sv
package fok_pkg;

  typedef enum logic [3:0] {
    FOK_IDLE,
    FOK_CHECK,
    FOK_OTP_READ,
    FOK_OTP_TEST,
    FOK_OTP_PROGRAM,
    FOK_OTP_SETTLE,
    FOK_OTP_VERIFY,
    FOK_ERASE_GO,
    FOK_ERASE_WAIT,
    FOK_ERASE_VERIFY,
    FOK_KEY_TEST,
    FOK_DONE
  } fok_state_type;

endpackage

// ===== fok_otp_store.sv
`timescale 1ns/1ps
`include "fok_regs.svh"

// info row records, written only by the sequencer
module fok_otp_store import fok_pkg::*; #(
  parameter int RECORDS = `FOK_OTP_RECORDS
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [$clog2(RECORDS)-1:0] i_index,
  input wire logic i_write,
  input wire logic [31:0] i_write_data,
  output logic [31:0] o_read_data
);

  logic [31:0] record_q [RECORDS];

  // programming only clears bits, never sets them
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < RECORDS; i++) begin
        record_q[i] <= `FOK_OTP_ERASED;
      end
    end else if (i_write) begin
      record_q[i_index] <= record_q[i_index] & i_write_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_read_data <= `FOK_OTP_ERASED;
    end else begin
      o_read_data <= record_q[i_index];
    end
  end

endmodule

// ===== fok_key_check.sv
`timescale 1ns/1ps
`include "fok_regs.svh"

// compares the supplied key with the stored comparison key
module fok_key_check import fok_pkg::*; (
  input wire logic [63:0] i_supplied_key,
  input wire logic [63:0] i_stored_key,
  output logic o_match,
  output logic o_forbidden
);

  logic [63:0] mapped_key;

  // key byte n sits at offset 3-n, key byte 4+n at offset 7-n
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_map
      assign mapped_key[8*(3-g) +: 8] = i_supplied_key[8*g +: 8];
      assign mapped_key[8*(7-g) +: 8] = i_supplied_key[8*(g+4) +: 8];
    end
  endgenerate

  assign o_match = (mapped_key == i_stored_key);
  assign o_forbidden = (i_supplied_key == `FOK_KEY_ZEROS) ||
                       (i_supplied_key == `FOK_KEY_ONES);

endmodule

// ===== fok_sequencer.sv
`timescale 1ns/1ps
`include "fok_regs.svh"

module fok_sequencer import fok_pkg::*; #(
  parameter int CMD_BYTES = `FOK_CMD_BYTES,
  parameter int RECORDS = `FOK_OTP_RECORDS
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_cmd_write,
  input wire logic [3:0] i_cmd_index,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_complete_clear,
  input wire logic i_error_clear,
  input wire logic i_command_allowed,
  input wire logic i_backdoor_unlock_enable,
  input wire logic i_any_region_protected,
  input wire logic [63:0] i_stored_key,
  input wire logic i_security_byte_unlocked,
  input wire logic i_external_wipe,
  input wire logic i_array_done,
  input wire logic i_array_erased,
  output logic [8*CMD_BYTES-1:0] o_command_object_bytes,
  output logic o_command_complete_flag,
  output logic o_access_error_flag,
  output logic o_protection_violation_flag,
  output logic o_verify_fail_flag,
  output logic o_unlocked,
  output logic o_external_wipe_request,
  output logic o_otp_block_read_invalid,
  output logic o_array_erase,
  output logic o_config_erase,
  output logic o_security_byte_program
);

  fok_state_type state_q;
  fok_state_type state_d;
  logic [CMD_BYTES-1:0][7:0] cmd_q;
  logic complete_q;
  logic access_err_q;
  logic prot_viol_q;
  logic verify_fail_q;
  logic unlocked_q;
  logic wipe_q;
  logic key_failed_q;
  logic lock_loaded_q;

  // command decode
  logic [7:0] code;
  logic [7:0] rec_index;
  logic [31:0] otp_data;
  logic [63:0] key_bytes;
  logic is_otp;
  logic is_erase;
  logic is_key;
  logic index_ok;
  logic code_known;
  assign code = cmd_q[`FOK_BYTE_CODE];
  assign rec_index = cmd_q[`FOK_BYTE_INDEX];
  assign otp_data = {cmd_q[`FOK_BYTE_DATA0+3], cmd_q[`FOK_BYTE_DATA0+2],
                     cmd_q[`FOK_BYTE_DATA0+1], cmd_q[`FOK_BYTE_DATA0]};
  assign is_otp = (code == `FOK_CMD_OTP_PGM);
  assign is_erase = (code == `FOK_CMD_ERASE_ALL);
  assign is_key = (code == `FOK_CMD_KEY_CHECK);
  assign index_ok = (rec_index <= `FOK_OTP_IDX_MAX);
  assign code_known = is_otp || is_erase || is_key;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_key
      assign key_bytes[8*g +: 8] = cmd_q[`FOK_BYTE_KEY0+g];
    end
  endgenerate

  // launch and wipe triggers
  logic launch;
  logic wipe_start;
  logic cmd_accept;
  assign launch = (state_q == FOK_IDLE) && complete_q && i_complete_clear;
  assign wipe_start = (state_q == FOK_IDLE) && complete_q && !i_complete_clear &&
                      i_external_wipe;
  assign cmd_accept = i_cmd_write && complete_q &&
                      (state_q == FOK_IDLE) && (32'(i_cmd_index) < CMD_BYTES);

  // one-time program record store
  logic [31:0] otp_read;
  logic otp_write;
  logic record_erased;
  logic readback_ok;
  logic [$clog2(RECORDS)-1:0] otp_index;
  assign otp_index = rec_index[$clog2(RECORDS)-1:0];
  assign otp_write = (state_q == FOK_OTP_PROGRAM);
  assign record_erased = (otp_read == `FOK_OTP_ERASED);
  assign readback_ok = (otp_read == otp_data);

  fok_otp_store #(
    .RECORDS(RECORDS)
  ) i_fok_otp_store (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_index(otp_index),
    .i_write(otp_write),
    .i_write_data(otp_data),
    .o_read_data(otp_read)
  );

  // backdoor key comparison
  logic key_match;
  logic key_forbidden;

  fok_key_check i_fok_key_check (
    .i_supplied_key(key_bytes),
    .i_stored_key(i_stored_key),
    .o_match(key_match),
    .o_forbidden(key_forbidden)
  );

  // check-state outcomes
  logic chk_access;
  logic chk_prot;
  assign chk_access = !i_command_allowed ||
                      !code_known ||
                      (is_otp && !index_ok) ||
                      (is_key && (!i_backdoor_unlock_enable || key_failed_q));
  assign chk_prot = is_erase && i_any_region_protected;

  // flag set terms
  logic set_access;
  logic set_prot;
  logic set_verify;
  logic set_unlock;
  logic key_mismatch;
  logic erase_pass;
  assign key_mismatch = (state_q == FOK_KEY_TEST) && !key_forbidden && !key_match;
  assign erase_pass = (state_q == FOK_ERASE_VERIFY) && i_array_erased;
  assign set_access = ((state_q == FOK_CHECK) && chk_access) ||
                      ((state_q == FOK_OTP_TEST) && !record_erased) ||
                      ((state_q == FOK_KEY_TEST) && key_forbidden) ||
                      key_mismatch;
  assign set_prot = (state_q == FOK_CHECK) && !chk_access && chk_prot;
  assign set_verify = ((state_q == FOK_OTP_VERIFY) && !readback_ok) ||
                      ((state_q == FOK_ERASE_VERIFY) && !i_array_erased);
  assign set_unlock = erase_pass ||
                      ((state_q == FOK_KEY_TEST) && !key_forbidden && key_match);

  // outputs toward the array
  logic erase_go;
  assign erase_go = (state_q == FOK_ERASE_GO);
  assign o_array_erase = erase_go;
  assign o_config_erase = erase_go && !wipe_q;
  assign o_security_byte_program = erase_pass && wipe_q;
  assign o_otp_block_read_invalid = (state_q == FOK_OTP_READ) ||
                                    (state_q == FOK_OTP_TEST) ||
                                    (state_q == FOK_OTP_PROGRAM) ||
                                    (state_q == FOK_OTP_SETTLE) ||
                                    (state_q == FOK_OTP_VERIFY);

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      FOK_IDLE: begin
        if (launch || wipe_start) begin
          state_d = launch ? FOK_CHECK : FOK_ERASE_GO;
        end
      end
      FOK_CHECK: begin
        if (chk_access || chk_prot) begin
          state_d = FOK_DONE;
        end else if (is_otp) begin
          state_d = FOK_OTP_READ;
        end else if (is_erase) begin
          state_d = FOK_ERASE_GO;
        end else begin
          state_d = FOK_KEY_TEST;
        end
      end
      FOK_OTP_READ: begin
        state_d = FOK_OTP_TEST;
      end
      FOK_OTP_TEST: begin
        state_d = record_erased ? FOK_OTP_PROGRAM : FOK_DONE;
      end
      FOK_OTP_PROGRAM: begin
        state_d = FOK_OTP_SETTLE;
      end
      FOK_OTP_SETTLE: begin
        state_d = FOK_OTP_VERIFY;
      end
      FOK_OTP_VERIFY: begin
        state_d = FOK_DONE;
      end
      FOK_ERASE_GO: begin
        state_d = FOK_ERASE_WAIT;
      end
      FOK_ERASE_WAIT: begin
        if (i_array_done) begin
          state_d = FOK_ERASE_VERIFY;
        end
      end
      FOK_ERASE_VERIFY: begin
        state_d = FOK_DONE;
      end
      FOK_KEY_TEST: begin
        state_d = FOK_DONE;
      end
      FOK_DONE: begin
        state_d = FOK_IDLE;
      end
      default: begin
        state_d = FOK_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= FOK_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // command object bytes
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_q <= {CMD_BYTES{`FOK_CMD_BYTE_RESET}};
    end else if (cmd_accept) begin
      cmd_q[i_cmd_index] <= i_cmd_data;
    end
  end

  // completion flag: clear on launch or wipe, set when done
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      complete_q <= 1'b0;
    end else if (state_q == FOK_DONE) begin
      complete_q <= 1'b1;
    end else if (launch || wipe_start) begin
      complete_q <= 1'b0;
    end else if (!lock_loaded_q) begin
      complete_q <= 1'b1;
    end
  end

  // error flags: a set in the clearing cycle wins
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      access_err_q <= 1'b0;
      prot_viol_q <= 1'b0;
    end else begin
      if (set_access) begin
        access_err_q <= 1'b1;
      end else if (i_error_clear) begin
        access_err_q <= 1'b0;
      end
      if (set_prot && !wipe_q) begin
        prot_viol_q <= 1'b1;
      end else if (i_error_clear) begin
        prot_viol_q <= 1'b0;
      end
    end
  end

  // verify failure is cleared by the next launch or wipe
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      verify_fail_q <= 1'b0;
    end else if (set_verify) begin
      verify_fail_q <= 1'b1;
    end else if (launch || wipe_start) begin
      verify_fail_q <= 1'b0;
    end
  end

  // lock state, loaded from the security byte after reset
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unlocked_q <= `FOK_LOCKED;
      lock_loaded_q <= 1'b0;
    end else begin
      lock_loaded_q <= 1'b1;
      if (set_unlock) begin
        unlocked_q <= `FOK_UNLOCKED;
      end else if (!lock_loaded_q) begin
        unlocked_q <= i_security_byte_unlocked;
      end
    end
  end

  // mismatch latch held until reset
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_failed_q <= 1'b0;
    end else if (key_mismatch) begin
      key_failed_q <= 1'b1;
    end
  end

  // external wipe in progress
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wipe_q <= 1'b0;
    end else if (wipe_start) begin
      wipe_q <= 1'b1;
    end else if (state_q == FOK_DONE) begin
      wipe_q <= 1'b0;
    end
  end

  assign o_command_object_bytes = cmd_q;
  assign o_command_complete_flag = complete_q;
  assign o_access_error_flag = access_err_q;
  assign o_protection_violation_flag = prot_viol_q;
  assign o_verify_fail_flag = verify_fail_q;
  assign o_unlocked = unlocked_q;
  assign o_external_wipe_request = wipe_q;

endmodule

// ===== fok_sequencer_sva.sv
`timescale 1ns/1ps
`include "fok_regs.svh"

module fok_sequencer_sva #(
  parameter int CMD_BYTES = `FOK_CMD_BYTES,
  parameter int RECORDS = `FOK_OTP_RECORDS
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_complete_clear,
  input wire logic i_command_allowed,
  input wire logic i_backdoor_unlock_enable,
  input wire logic i_any_region_protected,
  input wire logic [8*CMD_BYTES-1:0] o_command_object_bytes,
  input wire logic o_command_complete_flag,
  input wire logic o_access_error_flag,
  input wire logic o_protection_violation_flag,
  input wire logic o_external_wipe_request,
  input wire logic o_otp_block_read_invalid,
  input wire logic o_array_erase,
  input wire logic o_config_erase
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  // launch taken, and launch in a permitted mode
  wire go = o_command_complete_flag && i_complete_clear;
  wire ok = go && i_command_allowed;
  wire [7:0] code = o_command_object_bytes[7:0];
  wire [63:0] key = o_command_object_bytes[95:32];
  wire acc = o_command_complete_flag && o_access_error_flag;

  a_launch_clears_done: assert property (go |-> ##[1:2] !o_command_complete_flag)
    else $error("complete not cleared");
  a_mode_refused: assert property (go && !i_command_allowed |-> ##[2:5] acc)
    else $error("mode not refused");
  a_index_refused: assert property (ok && code == `FOK_CMD_OTP_PGM &&
    o_command_object_bytes[15:8] > `FOK_OTP_IDX_MAX |-> ##[2:5] acc) else $error("bad index");
  a_key_disabled: assert property (ok && code == `FOK_CMD_KEY_CHECK &&
    !i_backdoor_unlock_enable |-> ##[2:5] acc) else $error("disabled key ran");
  a_key_forbidden: assert property (ok && code == `FOK_CMD_KEY_CHECK &&
    (key == `FOK_KEY_ZEROS || key == `FOK_KEY_ONES) |-> ##[2:6] acc) else $error("bad key");
  a_protect_abort: assert property (ok && code == `FOK_CMD_ERASE_ALL &&
    i_any_region_protected |-> !o_array_erase throughout
    ##[2:5] (o_command_complete_flag && o_protection_violation_flag)) else $error("no abort");
  a_wipe_busy: assert property (o_external_wipe_request |-> !o_command_complete_flag)
    else $error("wipe flag while done");
  a_config_erase: assert property (o_config_erase |-> o_array_erase &&
    !o_external_wipe_request) else $error("config erase misplaced");
  a_read_invalid: assert property (o_otp_block_read_invalid |-> !o_command_complete_flag)
    else $error("invalid read while done");
  a_bytes_frozen: assert property (!o_command_complete_flag |=>
    $stable(o_command_object_bytes)) else $error("bytes changed while busy");

  c_key_launch: cover property (ok && code == `FOK_CMD_KEY_CHECK);
  c_otp_busy: cover property ($rose(o_otp_block_read_invalid));
  c_wipe: cover property ($rose(o_external_wipe_request));
endmodule

// ===== tb_fok_sequencer.sv
`timescale 1ns/1ps
`include "fok_regs.svh"

bind fok_sequencer fok_sequencer_sva #(.CMD_BYTES(CMD_BYTES), .RECORDS(RECORDS))
  i_fok_sequencer_sva (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_complete_clear(i_complete_clear), .i_command_allowed(i_command_allowed),
  .i_backdoor_unlock_enable(i_backdoor_unlock_enable),
  .i_any_region_protected(i_any_region_protected),
  .o_command_object_bytes(o_command_object_bytes),
  .o_command_complete_flag(o_command_complete_flag),
  .o_access_error_flag(o_access_error_flag),
  .o_protection_violation_flag(o_protection_violation_flag),
  .o_external_wipe_request(o_external_wipe_request),
  .o_otp_block_read_invalid(o_otp_block_read_invalid),
  .o_array_erase(o_array_erase), .o_config_erase(o_config_erase));

module tb_fok_sequencer;
  logic i_clock = 1'b0, i_reset_n = 1'b0, i_cmd_write = 1'b0, i_complete_clear = 1'b0;
  logic i_error_clear = 1'b0, i_command_allowed = 1'b1, i_backdoor_unlock_enable = 1'b1;
  logic i_any_region_protected = 1'b0, i_security_byte_unlocked = 1'b0;
  logic i_external_wipe = 1'b0, i_array_done = 1'b0, i_array_erased = 1'b1;
  logic [3:0] i_cmd_index = 4'h0;
  logic [7:0] i_cmd_data = 8'h00;
  logic [63:0] i_stored_key = 64'h0807_0605_0403_0201;
  logic [95:0] o_command_object_bytes;
  logic o_command_complete_flag, o_access_error_flag, o_protection_violation_flag;
  logic o_verify_fail_flag, o_unlocked, o_external_wipe_request, o_otp_block_read_invalid;
  logic o_array_erase, o_config_erase, o_security_byte_program;
  logic [4:0] sn;
  int error_cnt = 0, checked = 0, dly = 0;
  // done, access, protect, verify fail, unlocked, wipe request
  wire [5:0] st = {o_command_complete_flag, o_access_error_flag, o_protection_violation_flag,
    o_verify_fail_flag, o_unlocked, o_external_wipe_request};

  fok_sequencer i_fok_sequencer (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_cmd_write(i_cmd_write), .i_cmd_index(i_cmd_index), .i_cmd_data(i_cmd_data),
    .i_complete_clear(i_complete_clear), .i_error_clear(i_error_clear),
    .i_command_allowed(i_command_allowed), .i_backdoor_unlock_enable(i_backdoor_unlock_enable),
    .i_any_region_protected(i_any_region_protected), .i_stored_key(i_stored_key),
    .i_security_byte_unlocked(i_security_byte_unlocked), .i_external_wipe(i_external_wipe),
    .i_array_done(i_array_done), .i_array_erased(i_array_erased),
    .o_command_object_bytes(o_command_object_bytes),
    .o_command_complete_flag(o_command_complete_flag), .o_access_error_flag(o_access_error_flag),
    .o_protection_violation_flag(o_protection_violation_flag),
    .o_verify_fail_flag(o_verify_fail_flag), .o_unlocked(o_unlocked),
    .o_external_wipe_request(o_external_wipe_request),
    .o_otp_block_read_invalid(o_otp_block_read_invalid), .o_array_erase(o_array_erase),
    .o_config_erase(o_config_erase), .o_security_byte_program(o_security_byte_program));

  initial begin
    forever #4 i_clock = ~i_clock;
  end

  // array answers an erase a few cycles later
  always @(negedge i_clock) begin
    i_array_done = (dly == 1);
    dly = (o_array_erase === 1'b1) ? 3 : (dly > 0 ? dly - 1 : 0);
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_cmd_write = 1'b1;
    i_cmd_index = a;
    i_cmd_data = d;
    @(negedge i_clock);
    i_cmd_write = 1'b0;
    @(negedge i_clock);
  endtask

  // launch or wipe, optional write while busy, collect pulses
  task automatic run(input logic w, input logic p);
    int n;
    n = 0;
    sn = 5'h00;
    i_cmd_index = 4'h0;
    i_cmd_data = 8'h00;
    i_external_wipe = w;
    i_complete_clear = !w;
    i_error_clear = 1'b1;
    do begin
      @(posedge i_clock);
      #1;
      sn = sn | {o_external_wipe_request, o_security_byte_program, o_config_erase,
        o_array_erase, o_otp_block_read_invalid};
      @(negedge i_clock);
      n++;
      i_external_wipe = 1'b0;
      i_complete_clear = 1'b0;
      i_error_clear = 1'b0;
      i_cmd_write = p && n == 1;
    end while (n < 300 && (n < 3 || o_command_complete_flag !== 1'b1));
    if (n >= 300) begin
      error_cnt++;
      finish_test;
    end
    @(negedge i_clock);
  endtask

  task automatic rst(input logic s);
    i_reset_n = 1'b0;
    i_security_byte_unlocked = s;
    repeat (6) @(negedge i_clock);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_clock);
  endtask

  task automatic ldo(input logic [7:0] idx, input logic [31:0] d);
    wr(4'h0, `FOK_CMD_OTP_PGM);
    wr(4'h1, idx);
    for (int j = 0; j < 4; j++) begin
      wr(4'(4 + j), d[8*j+:8]);
    end
  endtask

  task automatic ldk(input logic [7:0] z, input logic [7:0] x);
    wr(4'h0, `FOK_CMD_KEY_CHECK);
    for (int j = 0; j < 8; j++) begin
      wr(4'(4 + j), (8'(j < 4 ? 4 - j : 12 - j) & z) ^ x);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    rst(1'b1);
    chk(st, 6'h22);
    rst(1'b0);
    ldo(8'h03, 32'h1234_5678);
    run(1'b0, 1'b0);
    chk({st, sn}, {6'h20, 5'h01});
    chk(o_command_object_bytes[63:0], 64'h1234_5678_0000_0343);
    run(1'b0, 1'b0);
    chk(st, 6'h30);
    ldo(8'h05, 32'hffff_ffff);
    run(1'b0, 1'b0);
    ldo(8'h05, 32'h0000_0000);
    run(1'b0, 1'b0);
    chk(st, 6'h20);
    run(1'b0, 1'b0);
    chk(st, 6'h30);
    ldo(8'h10, 32'h0000_0000);
    run(1'b0, 1'b0);
    chk({st, sn}, {6'h30, 5'h00});
    i_command_allowed = 1'b0;
    ldo(8'h06, 32'h0000_0000);
    run(1'b0, 1'b0);
    chk({st, sn}, {6'h30, 5'h00});
    i_command_allowed = 1'b1;
    run(1'b0, 1'b0);
    chk(st, 6'h20);
    wr(4'h0, `FOK_CMD_ERASE_ALL);
    i_any_region_protected = 1'b1;
    run(1'b0, 1'b0);
    chk({st, sn}, {6'h28, 5'h00});
    i_any_region_protected = 1'b0;
    i_array_erased = 1'b0;
    run(1'b0, 1'b0);
    chk({st, sn}, {6'h24, 5'h06});
    i_array_erased = 1'b1;
    run(1'b0, 1'b0);
    chk({st, sn}, {6'h22, 5'h06});
    ldo(8'h03, 32'h0000_0000);
    run(1'b0, 1'b0);
    chk(st, 6'h32);
    rst(1'b0);
    ldk(8'hff, 8'h00);
    i_backdoor_unlock_enable = 1'b0;
    run(1'b0, 1'b1);
    chk(st, 6'h30);
    chk(o_command_object_bytes[7:0], `FOK_CMD_KEY_CHECK);
    i_backdoor_unlock_enable = 1'b1;
    ldk(8'h00, 8'h00);
    run(1'b0, 1'b0);
    chk(st, 6'h30);
    ldk(8'hff, 8'h00);
    run(1'b0, 1'b0);
    chk(st, 6'h22);
    rst(1'b0);
    ldk(8'hff, 8'h01);
    run(1'b0, 1'b0);
    chk(st, 6'h30);
    ldk(8'hff, 8'h00);
    run(1'b0, 1'b0);
    chk(st, 6'h30);
    rst(1'b0);
    i_any_region_protected = 1'b1;
    run(1'b1, 1'b0);
    chk({st, sn}, {6'h22, 5'h1a});
    finish_test;
  end
endmodule
